// File: rtl/hc_port_regs.svh
// register offsets, field positions and reset values of the high-current output port
`ifndef HC_PORT_REGS_SVH
`define HC_PORT_REGS_SVH
`define DATA_OFS        16'hffdc
`define MODE_OFS        16'hffec
`define DATA_RST        8'hff
`define MODE_RST        8'hf0
`define MODE_RO_ONES    8'hf0
`define MODE_SEL_LSB    0
`define MODE_RSVD_BIT   2
`define MODE_SHDN_BIT   3
`define PIN_COUNT       6
`define BOOST_SETTLE_CYC 30
`define CNT_W           5
`endif

// File: rtl/hc_port_pkg.sv
// types of the high-current output port
package hc_port_pkg;
    typedef enum logic [1:0] {
        BOOST_OFF     = 2'b00,
        BOOST_SETTLE  = 2'b01,
        BOOST_READY   = 2'b10
    } boost_e;
endpackage

// File: rtl/high_current_output_port.sv
// six-pin high-current output port with boost control and modulator pin select
//
// Contract
// - 8-bit data register, low six drive pins
// - data register resets to all ones
// - 8-bit mode register selects pin zero/one function
// - mode bits 1:0 pick port or modulator
// - early clears get no large current
// - zero to one allowed at any time
// - variant: bit 3 plain reserved read/write
`timescale 1ns/100ps
`include "hc_port_regs.svh"

module high_current_output_port #(
    parameter bit HAS_BOOST = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        modulator_output_one,
    input  wire logic        modulator_output_two,
    output logic      [5:0]  port_pin_n,
    output logic      [5:0]  high_drive_en,
    output logic             boost_enable
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic        wr_pend_r;
    logic [15:0] wr_addr_r;
    logic [7:0]  data_r;
    logic [7:0]  data_nxt;
    logic [3:0]  mode_r;
    logic [3:0]  mode_nxt;
    logic [`CNT_W-1:0] settle_cnt_r;
    logic [`CNT_W-1:0] settle_cnt_nxt;
    logic [5:0]  strong_r;
    logic [5:0]  strong_nxt;
    hc_port_pkg::boost_e boost_r;
    hc_port_pkg::boost_e boost_nxt;

    wire addr_ok   = hsel && hready && htrans[1];
    wire wr_data   = wr_pend_r && (wr_addr_r == `DATA_OFS);
    wire wr_mode   = wr_pend_r && (wr_addr_r == `MODE_OFS);
    wire shdn      = HAS_BOOST && mode_r[`MODE_SHDN_BIT];
    wire [7:0] mode_rd = `MODE_RO_ONES | {4'h0, mode_r};
    wire [7:0] rd_byte = (haddr[15:0] == `DATA_OFS) ? data_r :
                         (haddr[15:0] == `MODE_OFS) ? mode_rd : 8'h00;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 16'h0000;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr[15:0];
            if (addr_ok && !hwrite) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    assign data_nxt = wr_data ? (hwdata[7:0] | 8'hc0) : data_r;
    // bit 2 stored as zero whatever is written; bit 3 is plain storage on variants
    assign mode_nxt = wr_mode ? {hwdata[3], 1'b0, hwdata[1:0]} : mode_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_r <= `DATA_RST;
            mode_r <= 4'h0;
        end else begin
            data_r <= data_nxt;
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boost circuit settling
    always_comb begin
        boost_nxt      = boost_r;
        settle_cnt_nxt = settle_cnt_r;
        unique case (boost_r)
            hc_port_pkg::BOOST_OFF: begin
                settle_cnt_nxt = '0;
                if (!shdn) begin
                    boost_nxt = hc_port_pkg::BOOST_SETTLE;
                end
            end
            hc_port_pkg::BOOST_SETTLE: begin
                if (shdn) begin
                    boost_nxt = hc_port_pkg::BOOST_OFF;
                end else if (settle_cnt_r == `CNT_W'(`BOOST_SETTLE_CYC - 1)) begin
                    boost_nxt = hc_port_pkg::BOOST_READY;
                end else begin
                    settle_cnt_nxt = settle_cnt_r + `CNT_W'(1);
                end
            end
            hc_port_pkg::BOOST_READY: begin
                if (shdn) begin
                    boost_nxt = hc_port_pkg::BOOST_OFF;
                end
            end
            default: begin
                boost_nxt = hc_port_pkg::BOOST_OFF;
            end
        endcase
    end

    // a pin driven low gets strong drive only if it went low after settling
    wire       ready   = (boost_r == hc_port_pkg::BOOST_READY);
    wire [5:0] falling = wr_data ? (data_r[5:0] & ~data_nxt[5:0]) : 6'h00;
    // drive stays only while the pin stays low and boost stays on
    assign strong_nxt  = (strong_r | (falling & {6{ready}})) & ~data_nxt[5:0] & {6{!shdn}};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boost_r      <= hc_port_pkg::BOOST_OFF;
            settle_cnt_r <= '0;
            strong_r     <= 6'h00;
        end else begin
            boost_r      <= boost_nxt;
            settle_cnt_r <= settle_cnt_nxt;
            strong_r     <= strong_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs
    assign port_pin_n[5:2] = data_r[5:2];
    assign port_pin_n[0]   = mode_r[`MODE_SEL_LSB] ? modulator_output_one : data_r[0];
    assign port_pin_n[1]   = mode_r[`MODE_SEL_LSB+1] ? modulator_output_two : data_r[1];
    assign high_drive_en   = strong_r;
    assign boost_enable    = !shdn;

    ////////////////////////////////////////////////////////////////////////
    // check helper: cycles spent settling, saturating
    logic [7:0] settle_run_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            settle_run_r <= 8'h00;
        end else if (boost_r == hc_port_pkg::BOOST_SETTLE) begin
            settle_run_r <= (settle_run_r == 8'hff) ? settle_run_r : settle_run_r + 8'h01;
        end else begin
            settle_run_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    data_reset_a: assert property (@(posedge clk_sys) !rst_n |=> data_r == `DATA_RST)
        else $error("data register not all ones after reset");
    mode_reset_a: assert property (@(posedge clk_sys) !rst_n |=> mode_rd == `MODE_RST)
        else $error("mode register reset value wrong");
    pin_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_r[0] |-> port_pin_n[0] == modulator_output_one)
        else $error("pin zero not routed to modulator");
    pin_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !mode_r[1] |-> port_pin_n[1] == data_r[1])
        else $error("pin one not routed to port data");
    settle_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ready) |-> settle_run_r >= 8'(`BOOST_SETTLE_CYC))
        else $error("boost ready before settle interval");
    pin_sel_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_r[1] |-> port_pin_n[1] == modulator_output_two)
        else $error("pin one not routed to modulator");
    pin_port_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !mode_r[0] |-> port_pin_n[0] == data_r[0])
        else $error("pin zero not routed to port data");
    pin_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_pin_n[5:2] == data_r[5:2])
        else $error("upper pins not following data register");
    data_top_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        data_r[7:6] == 2'b11)
        else $error("unused data bits not reading one");
    strong_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (high_drive_en & data_r[5:0]) == 6'h00)
        else $error("strong drive on a high pin");
    mode_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_mode |=> mode_r[3] == $past(hwdata[3]))
        else $error("mode bit 3 not stored");
    early_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_data && !ready |=> (strong_r & ~$past(strong_r)) == 6'h00)
        else $error("strong drive granted before settling");
    rise_any_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_data |=> data_r[5:0] == $past(hwdata[5:0]))
        else $error("data write not taken");
    shdn_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        shdn |=> high_drive_en == 6'h00)
        else $error("strong drive while boost shut down");
    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_rd[`MODE_RSVD_BIT] == 1'b0)
        else $error("reserved mode bit not zero");
    strong_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) high_drive_en != 6'h00);
    ready_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) ready);
    pwm_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r[1:0] == 2'b11);
    settle_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ready));
    early_cov: cover property (@(posedge clk_sys) disable iff (!rst_n)
        !ready && (falling != 6'h00));

endmodule // high_current_output_port

// File: dv/load_model.sv
// external loads on the high-current port pins
`timescale 1ns/100ps
module load_model (
    input  wire logic [5:0] port_pin_n,
    input  wire logic [5:0] high_drive_en,
    output logic      [5:0] heavy_sink
);
    // a low pin sinks a large current only with boosted drive behind it
    assign heavy_sink = ~port_pin_n & high_drive_en;
endmodule // load_model

// File: dv/tb_top.sv
// self-checking bench of the high-current output port
`timescale 1ns/100ps
`include "hc_port_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic        mod_one = 1'b0, mod_two = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, boost_enable;
    logic [5:0]  port_pin_n, high_drive_en, heavy_sink;
    logic [7:0]  q, v;
    int          miscompares = 0;
    int          checks = 0;
    high_current_output_port u_dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .modulator_output_one(mod_one), .modulator_output_two(mod_two), .port_pin_n,
        .high_drive_en, .boost_enable);
    load_model u_load (.port_pin_n, .high_drive_en, .heavy_sink);
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        mod_one <= 1'($urandom);
        mod_two <= 1'($urandom);
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_data(input logic [7:0] d);
        return {2'b11, d[5:0]};
    endfunction
    function automatic logic [7:0] exp_mode(input logic [7:0] d);
        return {4'hf, d[3], 1'b0, d[1:0]};
    endfunction
    task automatic final_report;
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                final_report;
            end
            @(posedge clk_sys);
        end
    endtask
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {16'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready;
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= {24'h0, d};
        wait_ready;
        q = hrdata[7:0];
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4383f4bf));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(`DATA_OFS, 1'b0, 8'h00);
        `CHK(q, `DATA_RST)
        bus(`MODE_OFS, 1'b0, 8'h00);
        `CHK(q, `MODE_RST)
        `CHK(port_pin_n, 6'h3f)
        bus(16'hffd0, 1'b1, 8'h5a);
        bus(16'hffd0, 1'b0, 8'h00);
        `CHK(q, 8'h00)
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom) & 8'hf3;
            bus(`MODE_OFS, 1'b1, v);
            bus(`MODE_OFS, 1'b0, 8'h00);
            `CHK(q, exp_mode(v))
            bus(`DATA_OFS, 1'b1, ~v);
            bus(`DATA_OFS, 1'b0, 8'h00);
            `CHK(q, exp_data(~v))
            `CHK(port_pin_n, {~v[5:2], v[1] ? mod_two : ~v[1], v[0] ? mod_one : ~v[0]})
        end
        // shutdown, early clear, then a clear after settling
        bus(`MODE_OFS, 1'b1, 8'h08);
        `CHK(boost_enable, 1'b0)
        bus(`DATA_OFS, 1'b1, 8'hff);
        bus(`MODE_OFS, 1'b1, 8'h00);
        `CHK(boost_enable, 1'b1)
        bus(`DATA_OFS, 1'b1, 8'h00);
        `CHK(port_pin_n, 6'h00)
        `CHK(heavy_sink, 6'h00)
        bus(`DATA_OFS, 1'b1, 8'hff);
        `CHK(port_pin_n, 6'h3f)
        repeat (30) @(posedge clk_sys);
        bus(`DATA_OFS, 1'b1, 8'hc0);
        `CHK(heavy_sink, 6'h3f)
        bus(`DATA_OFS, 1'b1, 8'hff);
        `CHK(port_pin_n, 6'h3f)
        bus(`MODE_OFS, 1'b1, 8'h08);
        `CHK(high_drive_en, 6'h00)
        final_report;
    end
endmodule // tb_top
